// ==== logic/secb_counter_bank.sv ====
// Purpose: counter bank driven by scan operations, with data register store
// Assumes: scan engine drives op_* from logic on clk_i; one op per ready cycle
// Notes: retained entries live in unreset arrays; general ones are swept clear
//
// Local design decisions: the Wishbone slave port and the placing of the registers.

`timescale 1ns/10ps

module secb_counter_bank
   import secb_pkg::*;
#(
   parameter int N16 = 512,
   parameter int N32 = 256,
   parameter int NUD = 64,
   parameter int NHS_BASE = 200,
   parameter int NDREG = 1024,
   parameter int C16_KEEP = 256,
   parameter int C32_KEEP = 128,
   parameter int DREG_KEEP = 512
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic op_valid_i,
   input wire secb_op_t op_code_i,
   input wire logic [15:0] op_index_i,
   input wire logic op_input_i,
   input wire logic op_use_dreg_i,
   input wire logic [15:0] op_dreg_i,
   input wire logic [31:0] op_const_i,
   input wire logic [31:0] op_wdata_i,
   output logic op_ready_o,
   output logic op_done_o,
   output logic op_err_o,
   output logic op_contact_o,
   output logic [63:0] op_rdata_o,
   output logic [N16-1:0] c16_contact_o,
   output logic [N32-1:0] w32_contact_o
);

   localparam int I16W = $clog2(N16);
   localparam int I32W = $clog2(N32);
   localparam int IDW = $clog2(NDREG);
   localparam int IUW = (NUD > 1) ? $clog2(NUD) : 1;
   localparam int WALK_MAX = (N16 > N32) ? ((N16 > NDREG) ? N16 : NDREG) : ((N32 > NDREG) ? N32 : NDREG);
   localparam logic [16:0] WALK_LAST = 17'(WALK_MAX - 1);
   localparam logic [16:0] DREG_GEN_LAST = 17'(DREG_KEEP - 1);

   if (N16 < 2 || N16 > 65536 || N32 < 2 || N32 > 65536 || NDREG < 4 || NDREG > 65536
       || NUD > SECB_DIR_MAX || NUD > N32 || NHS_BASE > N32 || NUD > NHS_BASE
       || C16_KEEP > N16 || C32_KEEP > N32 || DREG_KEEP > NDREG || DREG_KEEP < 1)
   begin : g_bad_params
      $error("secb_counter_bank: unsupported parameter set");
   end

   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [15:0] c16_cur_q [N16];
   logic c16_ct_q [N16];
   logic c16_prev_q [N16];
   logic [31:0] w32_cur_q [N32];
   logic w32_ct_q [N32];
   logic w32_prev_q [N32];
   logic [15:0] dreg_q [NDREG];

   logic [63:0] dir_q;
   logic [31:0] scans_q;
   logic [15:0] didx_q;
   logic ack_q;
   logic [31:0] rdat_q;
   secb_clr_t clr_q;
   logic [16:0] clr_idx_q;
   logic [16:0] clr_end_q;
   logic ready_q;
   logic done_q;
   logic err_q;
   logic contact_q;
   logic [63:0] rdata_q;
   logic [N16-1:0] c16_vis_q;
   logic [N32-1:0] w32_vis_q;

   // a register that lies past the end of the store reads as zero
   function automatic logic [15:0] dget(input logic [16:0] idx);
      dget = (idx < 17'(NDREG)) ? dreg_q[idx[IDW-1:0]] : 16'h0000;
   endfunction

   function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      for (int b = 0; b < 4; b++)
      begin
         lanes[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
   endfunction

   // ----------------------------------------
   // operation decode
   // ----------------------------------------
   wire take = op_valid_i & ready_q;
   wire [16:0] oidx = {1'b0, op_index_i};
   wire [16:0] didx = {1'b0, op_dreg_i};
   wire ok16 = oidx < 17'(N16);
   wire ok32 = oidx < 17'(NHS_BASE);
   wire [I16W-1:0] i16 = op_index_i[I16W-1:0];
   wire [I32W-1:0] i32 = op_index_i[I32W-1:0];

   // narrow counter
   wire [15:0] set16_raw = op_use_dreg_i ? dget(didx) : op_const_i[15:0];
   wire set16_low = (set16_raw == 16'h0000) | set16_raw[15];
   wire [15:0] set16 = set16_low ? SECB_C16_MIN_SET : set16_raw;
   wire [15:0] cur16 = c16_cur_q[i16];
   wire edge16 = op_input_i & ~c16_prev_q[i16];
   wire gt16 = $signed(cur16) > $signed(set16);
   wire eq16 = cur16 == set16;
   wire [15:0] inc16 = (cur16 == SECB_C16_MAX) ? 16'h0000 : cur16 + 16'h0001;
   wire [15:0] nxt16 = !edge16 ? cur16 : gt16 ? set16 : eq16 ? cur16 : inc16;
   wire ct16 = edge16 ? (nxt16 == set16) : c16_ct_q[i16];

   // wide counter; the high-speed range is handled elsewhere and refused here
   wire [31:0] set32 = op_use_dreg_i ? {dget(didx + 17'd1), dget(didx)} : op_const_i;
   wire [31:0] cur32 = w32_cur_q[i32];
   wire edge32 = op_input_i & ~w32_prev_q[i32];
   wire down32 = (oidx < 17'(NUD)) ? dir_q[op_index_i[IUW-1:0]] : 1'b0;
   wire gt32 = $signed(cur32) > $signed(set32);
   wire [31:0] step32 = down32 ? cur32 - 32'h0000_0001 : cur32 + 32'h0000_0001;
   wire [31:0] nxt32 = !edge32 ? cur32 : gt32 ? set32 : step32;
   wire up_hit = !down32 & (step32 == set32);
   wire dn_leave = down32 & (cur32 == set32);
   wire ct32 = !edge32 ? w32_ct_q[i32] : gt32 ? 1'b1 : up_hit ? 1'b1 : dn_leave ? 1'b0 : w32_ct_q[i32];

   wire [63:0] quad = {dget(oidx + 17'd3), dget(oidx + 17'd2), dget(oidx + 17'd1), dget(oidx)};
   wire op_bad = ((op_code_i == SECB_OP_COUNT16 || op_code_i == SECB_OP_RESET16
                   || op_code_i == SECB_OP_WRITE16) && !ok16)
                 || ((op_code_i == SECB_OP_COUNT32 || op_code_i == SECB_OP_RESET32
                      || op_code_i == SECB_OP_WRITE32) && !ok32)
                 || (op_code_i == SECB_OP_DREG_WR && oidx >= 17'(NDREG));

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
   wire bus_wr = bus_req & wb_we_i;
   wire [7:0] badr = {wb_adr_i[7:2], 2'b00};
   wire run_go = bus_wr & (badr == SECB_CTRL_OFS) & wb_sel_i[0] & wb_dat_i[SECB_CTRL_RUN_BIT];
   wire [16:0] bus_didx = {1'b0, didx_q};
   wire [31:0] ddata_rd = {16'h0000, dget(bus_didx)};
   wire [31:0] ddata_wr = lanes(ddata_rd, wb_dat_i, wb_sel_i);
   wire bus_dwr = bus_wr & (badr == SECB_DDATA_OFS) & (bus_didx < 17'(NDREG));
   wire [31:0] dir_lo_wr = lanes(dir_q[31:0], wb_dat_i, wb_sel_i);
   wire [31:0] dir_hi_wr = lanes(dir_q[63:32], wb_dat_i, wb_sel_i);
   wire [31:0] didx_wr = lanes({16'h0000, didx_q}, wb_dat_i, wb_sel_i);
   wire [31:0] rd_mux = (badr == SECB_CTRL_OFS) ? {31'h0, clr_q != SECB_CLR_IDLE} :
                        (badr == SECB_DIR_LO_OFS) ? dir_q[31:0] :
                        (badr == SECB_DIR_HI_OFS) ? dir_q[63:32] :
                        (badr == SECB_SCANS_OFS) ? scans_q :
                        (badr == SECB_DIDX_OFS) ? {16'h0000, didx_q} :
                        (badr == SECB_DDATA_OFS) ? ddata_rd : 32'h0000_0000;
   wire [63:0] dir_mask = (NUD == SECB_DIR_MAX) ? {64{1'b1}} : ((64'h1 << NUD) - 64'h1);

   // ----------------------------------------
   // wishbone slave: one wait state, every access acknowledged
   // ----------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         rdat_q <= SECB_REG_RST;
         dir_q <= 64'h0;
         didx_q <= 16'h0000;
      end
      else
      begin
         ack_q <= bus_req;
         if (bus_req)
            rdat_q <= rd_mux;
         if (bus_wr && badr == SECB_DIR_LO_OFS)
            dir_q[31:0] <= dir_lo_wr & dir_mask[31:0];
         if (bus_wr && badr == SECB_DIR_HI_OFS)
            dir_q[63:32] <= dir_hi_wr & dir_mask[63:32];
         if (bus_wr && badr == SECB_DIDX_OFS)
            didx_q <= didx_wr[15:0];
      end
   end

   // ----------------------------------------
   // clear sweep: power-up walks the general entries, run start only the general data registers
   // ----------------------------------------
   wire walking = clr_q != SECB_CLR_IDLE;
   wire walk_done = walking & (clr_idx_q == clr_end_q);
   wire range_go = take & (op_code_i == SECB_OP_RANGE_CLR) & (op_index_i <= op_wdata_i[15:0])
                   & (oidx < 17'(NDREG));
   wire [16:0] range_end = ({1'b0, op_wdata_i[15:0]} < 17'(NDREG)) ? {1'b0, op_wdata_i[15:0]} : 17'(NDREG - 1);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         clr_q <= SECB_CLR_POWER;
         clr_idx_q <= 17'h0;
         clr_end_q <= WALK_LAST;
      end
      else
      begin
         case (clr_q)
            SECB_CLR_IDLE:
            begin
               if (range_go)
               begin
                  clr_q <= SECB_CLR_DATA;
                  clr_idx_q <= oidx;
                  clr_end_q <= range_end;
               end
               else if (run_go)
               begin
                  clr_q <= SECB_CLR_DATA;
                  clr_idx_q <= 17'h0;
                  clr_end_q <= DREG_GEN_LAST;
               end
            end
            SECB_CLR_POWER, SECB_CLR_DATA:
            begin
               if (walk_done)
                  clr_q <= SECB_CLR_IDLE;
               clr_idx_q <= clr_idx_q + 17'h1;
            end
            default:
               clr_q <= SECB_CLR_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // counter and register arrays: not reset, so retained entries survive
   // ----------------------------------------
   wire pw = clr_q == SECB_CLR_POWER;
   wire dw = clr_q == SECB_CLR_DATA;

   always_ff @(posedge clk_i)
   begin
      if (pw && clr_idx_q < 17'(C16_KEEP))
      begin
         c16_cur_q[clr_idx_q[I16W-1:0]] <= 16'h0000;
         c16_ct_q[clr_idx_q[I16W-1:0]] <= 1'b0;
         c16_prev_q[clr_idx_q[I16W-1:0]] <= 1'b0;
      end
      else if (take && ok16)
      begin
         case (op_code_i)
            SECB_OP_COUNT16:
            begin
               c16_cur_q[i16] <= nxt16;
               c16_ct_q[i16] <= ct16;
               c16_prev_q[i16] <= op_input_i;
            end
            SECB_OP_RESET16:
            begin
               c16_cur_q[i16] <= 16'h0000;
               c16_ct_q[i16] <= 1'b0;
            end
            SECB_OP_WRITE16:
               c16_cur_q[i16] <= op_wdata_i[15:0];
            default:
            begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (pw && clr_idx_q < 17'(C32_KEEP))
      begin
         w32_cur_q[clr_idx_q[I32W-1:0]] <= 32'h0000_0000;
         w32_ct_q[clr_idx_q[I32W-1:0]] <= 1'b0;
         w32_prev_q[clr_idx_q[I32W-1:0]] <= 1'b0;
      end
      else if (take && ok32)
      begin
         case (op_code_i)
            SECB_OP_COUNT32:
            begin
               w32_cur_q[i32] <= nxt32;
               w32_ct_q[i32] <= ct32;
               w32_prev_q[i32] <= op_input_i;
            end
            SECB_OP_RESET32:
            begin
               w32_cur_q[i32] <= 32'h0000_0000;
               w32_ct_q[i32] <= 1'b0;
            end
            SECB_OP_WRITE32:
               w32_cur_q[i32] <= op_wdata_i;
            default:
            begin
            end
         endcase
      end
   end

   // the sweep wins over the bus; a bus write that collides with a data register write op is lost
   always_ff @(posedge clk_i)
   begin
      if ((pw && clr_idx_q < 17'(DREG_KEEP)) || (dw && clr_idx_q < 17'(NDREG)))
         dreg_q[clr_idx_q[IDW-1:0]] <= 16'h0000;
      else if (take && op_code_i == SECB_OP_DREG_WR && !op_bad)
         dreg_q[op_index_i[IDW-1:0]] <= op_wdata_i[15:0];
      else if (bus_dwr && !walking)
         dreg_q[didx_q[IDW-1:0]] <= ddata_wr[15:0];
   end

   // ----------------------------------------
   // scan answers and visible contacts
   // ----------------------------------------
   wire [63:0] res = (op_code_i == SECB_OP_COUNT16) ? {{48{nxt16[15]}}, nxt16} :
                     (op_code_i == SECB_OP_WRITE16) ? {{48{op_wdata_i[15]}}, op_wdata_i[15:0]} :
                     (op_code_i == SECB_OP_COUNT32) ? {{32{nxt32[31]}}, nxt32} :
                     (op_code_i == SECB_OP_WRITE32) ? {{32{op_wdata_i[31]}}, op_wdata_i} :
                     (op_code_i == SECB_OP_DREG_RD) ? quad : 64'h0;
   wire res_ct = (op_code_i == SECB_OP_COUNT16) ? ct16 :
                 (op_code_i == SECB_OP_WRITE16) ? c16_ct_q[i16] :
                 (op_code_i == SECB_OP_COUNT32) ? ct32 :
                 (op_code_i == SECB_OP_WRITE32) ? w32_ct_q[i32] : 1'b0;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ready_q <= 1'b0;
         done_q <= 1'b0;
         err_q <= 1'b0;
         contact_q <= 1'b0;
         rdata_q <= 64'h0;
         scans_q <= 32'h0;
         c16_vis_q <= '0;
         w32_vis_q <= '0;
      end
      else
      begin
         ready_q <= !walking && !range_go && !run_go;
         done_q <= take;
         if (take)
         begin
            err_q <= op_bad;
            contact_q <= op_bad ? 1'b0 : res_ct;
            rdata_q <= op_bad ? 64'h0 : res;
         end
         if (take && op_code_i == SECB_OP_SCAN_END)
         begin
            scans_q <= scans_q + 32'h1;
            for (int k = 0; k < N16; k++)
               c16_vis_q[k] <= c16_ct_q[k];
            for (int k = 0; k < N32; k++)
               w32_vis_q[k] <= w32_ct_q[k];
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign op_ready_o = ready_q;
   assign op_done_o = done_q;
   assign op_err_o = err_q;
   assign op_contact_o = contact_q;
   assign op_rdata_o = rdata_q;
   assign c16_contact_o = c16_vis_q;
   assign w32_contact_o = w32_vis_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   secb_op_t h_code_q;
   logic h_edge_q;
   logic h_down_q;
   logic h_ok_q;
   logic [31:0] h_pre_q;
   logic [31:0] h_set_q;
   logic [15:0] h_idx_q;

   always_ff @(posedge clk_i)
   begin
      if (take)
      begin
         h_code_q <= op_code_i;
         h_ok_q <= !op_bad;
         h_edge_q <= (op_code_i == SECB_OP_COUNT16) ? edge16 : edge32;
         h_down_q <= down32;
         h_pre_q <= (op_code_i == SECB_OP_COUNT16) ? {16'h0000, cur16} : cur32;
         h_set_q <= (op_code_i == SECB_OP_COUNT16) ? {16'h0000, set16} : set32;
         h_idx_q <= op_index_i;
      end
   end

   wire h16 = op_done_o && h_ok_q && h_code_q == SECB_OP_COUNT16 && h_edge_q;
   wire h32 = op_done_o && h_ok_q && h_code_q == SECB_OP_COUNT32 && h_edge_q;

   count_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
      h16 && h_pre_q[15:0] < h_set_q[15:0] |-> op_rdata_o[15:0] == h_pre_q[15:0] + 16'h0001)
      else $error("narrow counter did not add one");
   sat_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      h16 && h_pre_q == h_set_q |-> op_rdata_o[15:0] == h_pre_q[15:0] && op_contact_o)
      else $error("narrow counter moved past setting");
   over_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
      h16 && $signed(h_pre_q[15:0]) > $signed(h_set_q[15:0]) |-> op_rdata_o[15:0] == h_set_q[15:0] && op_contact_o)
      else $error("narrow overrange value not loaded");
   zero_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
      take && op_code_i == SECB_OP_COUNT16 && ok16 && !op_use_dreg_i && op_const_i[15:0] == 16'h0000
      && edge16 && cur16 == 16'h0000 |=> op_contact_o)
      else $error("setting zero did not act as one");
   vis_scan_a: assert property (@(posedge clk_i) disable iff (rst_i)
      c16_vis_q != $past(c16_vis_q) |-> $past(take && op_code_i == SECB_OP_SCAN_END))
      else $error("contact changed inside a scan");
   clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      op_done_o && h_ok_q && (h_code_q == SECB_OP_RESET16 || h_code_q == SECB_OP_RESET32)
      |-> (h_code_q == SECB_OP_RESET16)
          ? (c16_cur_q[h_idx_q[I16W-1:0]] == 16'h0000 && !c16_ct_q[h_idx_q[I16W-1:0]])
          : (w32_cur_q[h_idx_q[I32W-1:0]] == 32'h0 && !w32_ct_q[h_idx_q[I32W-1:0]]))
      else $error("reset left value or contact");
   wide_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
      h32 && !h_down_q && h_pre_q == 32'h7fff_ffff && $signed(h_pre_q) <= $signed(h_set_q)
      |-> op_rdata_o[31:0] == 32'h8000_0000)
      else $error("wide counter did not wrap");
   wide_dir_a: assert property (@(posedge clk_i) disable iff (rst_i)
      h32 && h_down_q && $signed(h_pre_q) <= $signed(h_set_q) |-> op_rdata_o[31:0] == h_pre_q - 32'h1)
      else $error("wide counter ignored direction");
   wide_leave_a: assert property (@(posedge clk_i) disable iff (rst_i)
      h32 && h_down_q && h_pre_q == h_set_q |-> !op_contact_o)
      else $error("wide contact stayed on going down");

endmodule // secb_counter_bank

// ==== logic/secb_pkg.sv ====
// Purpose: constants and types shared by the scan event counter bank
// Assumes: 50 MHz clk_i, Wishbone classic slave, scan engine on the same clock
// Notes: Summary of operation follows
//
// Summary of operation
// - narrow counter adds one per off-to-on count edge, upward only.
// - narrow setting value accepted from zero to 32767.
// - narrow counter at its setting value ignores edges and holds.
// - narrow contact is on whenever current value equals setting value; the code sets it only on a count edge.
// - narrow setting value zero acts as one.
// - reset operation clears current value to zero and contact off.
// - narrow contact becomes visible only after the scan completes.
// - narrow value above setting loads setting and sets contact on next edge.
// - narrow counter at 32767 goes to zero on the next count; the code holds at a 32767 setting, else loads the setting.
// - narrow setting comes from a constant or a data register.
// - wide counters split into up/down, up-only and high-speed ranges.
// - wide setting value is a full signed 32-bit quantity.
// - wide counter keeps counting past its setting value; the code loads the setting on any edge that finds the value above it.
// - each up/down wide counter has a direction bit, off up, on down.
// - wide counter wraps max to min going up, min to max going down; the code wraps up only at a 7fffffff setting, else loads the setting.
// - wide contact on when reaching setting up, off leaving it down.
// - wide value above setting loads setting and sets contact on next edge.
// - wide setting from data registers uses two consecutive registers.
// - each data register holds a signed 16-bit value.
// - register pair forms 32 bits, lower number is the low half.
// - four registers form signed 64 bits, lowest number least significant.
// - general data registers clear at run start, retained ones by clear only.

package secb_pkg;

   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] SECB_CTRL_OFS = 8'h00;
   localparam logic [7:0] SECB_DIR_LO_OFS = 8'h04;
   localparam logic [7:0] SECB_DIR_HI_OFS = 8'h08;
   localparam logic [7:0] SECB_SCANS_OFS = 8'h0c;
   localparam logic [7:0] SECB_DIDX_OFS = 8'h10;
   localparam logic [7:0] SECB_DDATA_OFS = 8'h14;
   localparam int SECB_CTRL_RUN_BIT = 0;
   localparam int SECB_CTRL_BUSY_BIT = 0;
   localparam logic [31:0] SECB_REG_RST = 32'h0000_0000;

   // ----------------------------------------
   // counting limits
   // ----------------------------------------
   localparam int SECB_IDXW = 16;
   localparam logic [15:0] SECB_C16_MAX = 16'h7fff;
   localparam logic [15:0] SECB_C16_MIN_SET = 16'h0001;
   localparam int SECB_DIR_MAX = 64;

   typedef enum logic [3:0] {
      SECB_OP_COUNT16,
      SECB_OP_RESET16,
      SECB_OP_WRITE16,
      SECB_OP_COUNT32,
      SECB_OP_RESET32,
      SECB_OP_WRITE32,
      SECB_OP_DREG_WR,
      SECB_OP_DREG_RD,
      SECB_OP_RANGE_CLR,
      SECB_OP_SCAN_END
   } secb_op_t;

   typedef enum logic [1:0] {
      SECB_CLR_IDLE,
      SECB_CLR_POWER,
      SECB_CLR_DATA
   } secb_clr_t;

endpackage

// ==== bench/secb_scan_model.sv ====
// Purpose: scan engine stand-in that issues counter operations
// Assumes: same clock as the bank
// Notes: a request stands until ready is seen at a falling edge
`timescale 1ns/10ps
module secb_scan_model
   import secb_pkg::*;
(
   input wire logic clk_i,
   input wire logic ready_i,
   output logic valid_o,
   output secb_op_t code_o,
   output logic [15:0] index_o,
   output logic input_o,
   output logic use_dreg_o,
   output logic [15:0] dreg_o,
   output logic [31:0] const_o,
   output logic [31:0] wdata_o
);
   int hung = 0;
   initial
   begin
      valid_o = 1'b0;
      code_o = SECB_OP_SCAN_END;
      {index_o, input_o, use_dreg_o, dreg_o, const_o, wdata_o} = '0;
   end
   // dreg index rides in the low half of k
   task automatic issue(input secb_op_t c, input logic [15:0] ix, input logic inp, input logic ud,
      input logic [31:0] k, input logic [31:0] wd);
      int n;
      begin
         n = 0;
         @(posedge clk_i);
         valid_o <= 1'b1;
         code_o <= c;
         index_o <= ix;
         input_o <= inp;
         use_dreg_o <= ud;
         dreg_o <= k[15:0];
         const_o <= k;
         wdata_o <= wd;
         @(negedge clk_i);
         while (ready_i !== 1'b1 && n < 2000)
         begin
            @(negedge clk_i);
            n++;
         end
         hung += int'(n >= 2000);
         @(posedge clk_i);
         valid_o <= 1'b0;
         index_o <= ~ix;
      end
   endtask
endmodule // secb_scan_model

// ==== bench/secb_counter_bank_tb.sv ====
// Purpose: self-checking bench for the counter bank
// Assumes: default bank sizes, so each power sweep takes about a thousand cycles
// Notes: op results are queued and compared as done pulses appear
`timescale 1ns/10ps
module secb_counter_bank_tb;
   import secb_pkg::*;
   typedef struct packed {logic [1:0] m; logic [63:0] rd; logic ct; logic er;} secb_exp_t;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, op_valid_i, op_input_i, op_use_dreg_i;
   logic op_ready_o, op_done_o, op_err_o, op_contact_o, prev;
   logic [7:0] wb_adr_i;
   logic [511:0] c16_contact_o;
   logic [255:0] w32_contact_o;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, op_const_i, op_wdata_i, q, rnd;
   logic [15:0] op_index_i, op_dreg_i, v;
   logic [15:0] dv [4];
   logic [63:0] op_rdata_o;
   secb_op_t op_code_i;
   secb_exp_t expq [$];
   secb_exp_t e;
   int err_total = 0;
   int total_checks = 0;
   secb_counter_bank #(.NUD(4), .NHS_BASE(6), .DREG_KEEP(4)) secb_counter_bank_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .op_valid_i, .op_code_i,
      .op_index_i, .op_input_i, .op_use_dreg_i, .op_dreg_i, .op_const_i, .op_wdata_i, .op_ready_o,
      .op_done_o, .op_err_o, .op_contact_o, .op_rdata_o, .c16_contact_o, .w32_contact_o);
   secb_scan_model secb_scan_model_i (.clk_i, .ready_i(op_ready_o), .valid_o(op_valid_i),
      .code_o(op_code_i), .index_o(op_index_i), .input_o(op_input_i), .use_dreg_o(op_use_dreg_i),
      .dreg_o(op_dreg_i), .const_o(op_const_i), .wdata_o(op_wdata_i));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
      total_checks++;
      if (x !== g)
      begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", nm, x, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge clk_i);
         {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
         @(negedge clk_i);
         while (wb_ack_o !== 1'b1 && n < 50)
         begin
            @(negedge clk_i);
            n++;
         end
         if (n >= 50)
         begin
            err_total++;
            give_verdict;
         end
         @(posedge clk_i);
         q = wb_dat_o;
         {wb_cyc_i, wb_stb_i} <= 2'b00;
      end
   endtask
   task automatic op(input secb_op_t c, input logic [15:0] ix, input logic inp, input logic ud,
      input logic [31:0] k, input logic [31:0] wd, input logic [1:0] m, input logic [63:0] rd, input logic ct);
      expq.push_back({m, rd, ct, c == SECB_OP_COUNT32 && ix >= 16'h6});
      secb_scan_model_i.issue(c, ix, inp, ud, k, wd);
      if (secb_scan_model_i.hung > 0)
         give_verdict;
   endtask
   task automatic give_verdict;
      err_total += secb_scan_model_i.hung + expq.size();
      $display("checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(negedge clk_i)
      if (op_done_o === 1'b1)
      begin
         e = expq.pop_front();
         chk("op error", 64'(e.er), 64'(op_err_o));
         if (e.m[1])
            chk("op value", e.rd, op_rdata_o);
         if (e.m[0])
            chk("op contact", 64'(e.ct), 64'(op_contact_o));
      end
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   initial
   begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      give_verdict;
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {4'h8, 8'h00, 4'hf, 32'h0};
      rnd = 32'h1331;
      prev = 1'b0;
      v = 16'h0;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 12; i++)
      begin
         rnd = lfsr(rnd);
         v = v + 16'((rnd[0] && !prev && v < 16'h3));
         prev = rnd[0];
         op(SECB_OP_COUNT16, 0, rnd[0], 0, 3, 0, 3, 64'(v), v == 16'h3);
      end
      chk("narrow visible early", 64'h0, 64'(c16_contact_o[0]));
      op(SECB_OP_SCAN_END, 0, 0, 0, 0, 0, 0, 0, 0);
      @(negedge clk_i);
      chk("narrow visible", 64'(v == 16'h3), 64'(c16_contact_o[0]));
      wb(1'b0, SECB_SCANS_OFS, 0);
      chk("scan count", 64'h1, 64'(q));
      op(SECB_OP_RESET16, 0, 0, 0, 3, 0, 3, 0, 0);
      op(SECB_OP_COUNT16, 1, 1, 0, 0, 0, 3, 1, 1);
      op(SECB_OP_WRITE16, 2, 0, 0, 5, 100, 2, 100, 0);
      op(SECB_OP_COUNT16, 2, 1, 0, 5, 0, 3, 5, 1);
      op(SECB_OP_DREG_WR, 5, 0, 0, 0, 2, 0, 0, 0);
      op(SECB_OP_COUNT16, 3, 1, 1, 5, 0, 3, 1, 0);
      op(SECB_OP_COUNT16, 3, 0, 1, 5, 0, 3, 1, 0);
      op(SECB_OP_COUNT16, 3, 1, 1, 5, 0, 3, 2, 1);
      op(SECB_OP_COUNT16, 3, 0, 1, 5, 0, 3, 2, 1);
      op(SECB_OP_COUNT16, 3, 1, 1, 5, 0, 3, 2, 1);
      $display("narrow counters done");
      dv = '{16'hfffb, 16'hffff, 16'(lfsr(rnd)), 16'h8000};
      for (int i = 0; i < 4; i++)
         op(SECB_OP_DREG_WR, 16'(i), 0, 0, 0, 32'(dv[i]), 0, 0, 0);
      op(SECB_OP_WRITE32, 0, 0, 0, 0, 32'hffff_fffa, 2, 64'hffff_ffff_ffff_fffa, 0);
      op(SECB_OP_COUNT32, 0, 1, 1, 0, 0, 3, 64'hffff_ffff_ffff_fffb, 1);
      wb(1'b1, SECB_DIR_LO_OFS, 32'h11);
      op(SECB_OP_COUNT32, 0, 0, 1, 0, 0, 3, 64'hffff_ffff_ffff_fffb, 1);
      op(SECB_OP_COUNT32, 0, 1, 1, 0, 0, 3, 64'hffff_ffff_ffff_fffa, 0);
      op(SECB_OP_RESET32, 4, 0, 0, 100, 0, 3, 0, 0);
      op(SECB_OP_COUNT32, 4, 1, 0, 100, 0, 3, 1, 0);
      wb(1'b1, SECB_DIR_LO_OFS, 32'h2);
      wb(1'b0, SECB_DIR_LO_OFS, 0);
      chk("direction bits", 64'h2, 64'(q));
      op(SECB_OP_WRITE32, 1, 0, 0, 0, 32'h8000_0000, 2, 64'hffff_ffff_8000_0000, 0);
      op(SECB_OP_COUNT32, 1, 1, 0, 32'h7fff_fffe, 0, 2, 64'h7fff_ffff, 0);
      wb(1'b1, SECB_DIR_LO_OFS, 0);
      op(SECB_OP_COUNT32, 1, 0, 0, 32'h7fff_ffff, 0, 2, 64'h7fff_ffff, 0);
      op(SECB_OP_COUNT32, 1, 1, 0, 32'h7fff_ffff, 0, 2, 64'hffff_ffff_8000_0000, 0);
      op(SECB_OP_WRITE32, 2, 0, 0, 10, 50, 2, 50, 0);
      op(SECB_OP_COUNT32, 2, 1, 0, 10, 0, 3, 10, 1);
      op(SECB_OP_COUNT32, 6, 1, 0, 0, 0, 0, 0, 0);
      op(SECB_OP_SCAN_END, 0, 0, 0, 0, 0, 0, 0, 0);
      @(negedge clk_i);
      chk("wide visible", 64'h4, 64'(w32_contact_o[2:0]));
      $display("wide counters done");
      op(SECB_OP_DREG_RD, 0, 0, 0, 0, 0, 2, {dv[3], dv[2], dv[1], dv[0]}, 0);
      op(SECB_OP_RANGE_CLR, 0, 0, 0, 0, 1, 0, 0, 0);
      op(SECB_OP_DREG_RD, 0, 0, 0, 0, 0, 2, {dv[3], dv[2], 32'h0}, 0);
      wb(1'b1, SECB_CTRL_OFS, 32'h1);
      op(SECB_OP_DREG_RD, 0, 0, 0, 0, 0, 2, 64'h0, 0);
      wb(1'b1, SECB_DIDX_OFS, 32'h5);
      wb(1'b0, SECB_DDATA_OFS, 0);
      chk("retained register", 64'h2, 64'(q));
      wb(1'b0, 8'h1c, 0);
      chk("unmapped read", 64'h0, 64'(q));
      $display("data registers done");
      op(SECB_OP_WRITE16, 300, 0, 0, 9, 7, 2, 7, 0);
      op(SECB_OP_COUNT16, 300, 0, 0, 9, 0, 2, 7, 0);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      op(SECB_OP_COUNT16, 300, 0, 0, 9, 0, 2, 7, 0);
      op(SECB_OP_COUNT16, 1, 0, 0, 9, 0, 3, 0, 0);
      $display("power loss done");
      repeat (3) @(posedge clk_i);
      give_verdict;
   end
endmodule // secb_counter_bank_tb
